// >>> logic/rfog_regs.sv
// rfog_regs: focus offset, rf gain and rf offset register bank behind an
// avalon-mm slave; control words are routed by their top nibble.
// assumes synchronous inputs on SYS_CLK and a master that holds its
// request until waitrequest is seen low.
//
// How it works
// - a word with select 0010 loads the focus offset register.
// - focus bit 11 turns the alternate operating mode off (0) or on (1).
// - focus bit 10 is inverted: 0 turns full-range focus offset on.
// - focus bits 9..5 give a fraction of 0 to 31/32 in 1/32 steps.
// - a word with select 0011 loads the rf gain register.
// - first stage gain 00/01/10 is 0/6/12 dB; a write of 11 is ignored.
// - second stage gain 00..11 gives 6, 12, 18, 24 dB.
// - third stage gain bits 7..4 step 0.8 dB over sixteen codes.
// - a word with select 0100 loads the left/right offset register.
// - left field drives the left converter only with summed input off.
// - right field drives the right converter with summed input off.
// - summed on, source 0: right field drives phase and summed converters.
// - summed on, source 1: the left/right low field has no effect.
// - a word with select 0101 loads the sum offset register.
// - sum field drives summed converter only with summed on, source 1.
// - mode bit 0 picks diode inputs (0) or summed rf input (1).
// - mode bit 11 sources the phase converter from left/right or sum field.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module rfog_regs
(
  // clock and reset
  input  wire  logic        SYS_CLK,
  input  wire  logic        RESET,
  // avalon-mm slave
  input  wire  logic [5:0]  AVS_ADDRESS,
  input  wire  logic        AVS_READ,
  input  wire  logic        AVS_WRITE,
  input  wire  logic [31:0] AVS_WRITEDATA,
  input  wire  logic [3:0]  AVS_BYTEENABLE,
  output logic       [31:0] AVS_READDATA,
  output logic              AVS_WAITREQUEST,
  // focus offset controls
  output logic              ALTERNATE_OPERATING_MODE,
  output logic              FOCUS_FULL_RANGE_OFFSET_ON,
  output logic       [4:0]  FOCUS_OFFSET_FRACTION,
  // rf gain controls
  output logic       [1:0]  FIRST_STAGE_GAIN_CODE,
  output logic       [1:0]  SECOND_STAGE_GAIN_CODE,
  output logic       [3:0]  THIRD_STAGE_GAIN_CODE,
  output logic       [4:0]  FIRST_STAGE_GAIN_DB,
  output logic       [4:0]  SECOND_STAGE_GAIN_DB,
  output logic       [7:0]  THIRD_STAGE_GAIN_TENTH_DB,
  // rf input and offset converters
  output logic              SUMMED_INPUT_SELECT,
  output logic              PHASE_OFFSET_SOURCE_SELECT,
  output logic       [5:0]  LEFT_CHANNEL_OFFSET_CODE,
  output logic       [5:0]  RIGHT_CHANNEL_OFFSET_CODE,
  output logic       [5:0]  SUMMED_CHANNEL_OFFSET_CODE,
  output logic       [5:0]  PHASE_DETECTOR_OFFSET_CODE
);

  // register index from a byte address
  function automatic logic [3:0] idx_of(input logic [5:0] addr);
    idx_of = addr[5:2];
  endfunction : idx_of

  // true when a control word carries the given register select
  function automatic logic sel_is(input logic [15:0] word, input logic [3:0] sel);
    sel_is = (word[rfog_pkg::SEL_HI:rfog_pkg::SEL_LO] == sel);
  endfunction : sel_is

  function automatic logic [4:0] g1_db(input logic [1:0] code);
    g1_db = 5'(code * rfog_pkg::G1_STEP_DB);
  endfunction : g1_db

  function automatic logic [4:0] g2_db(input logic [1:0] code);
    g2_db = 5'(rfog_pkg::G2_BASE_DB + code * rfog_pkg::G2_STEP_DB);
  endfunction : g2_db

  function automatic logic [7:0] g3_tdb(input logic [3:0] code);
    g3_tdb = 8'(code * rfog_pkg::G3_STEP_TDB);
  endfunction : g3_tdb

  rfog_pkg::rfog_bus_t bus_state_r;
  logic                wait_r;
  logic [31:0]         rdata_r;
  logic [15:0]         last_word_r;
  logic                word_wr;
  logic [15:0]         word;

  // stored fields
  logic                sumsel_r;
  logic                phsrc_r;
  logic                altmode_r;
  logic                foff_off_r;
  logic [4:0]          frac_r;
  logic [1:0]          g1_r;
  logic [1:0]          g2_r;
  logic [3:0]          g3_r;
  logic [5:0]          left_r;
  logic [5:0]          right_r;
  logic [5:0]          sumf_r;

  logic [5:0]          conv_left;
  logic [5:0]          conv_right;
  logic [5:0]          conv_sum;
  logic [5:0]          conv_phase;
  logic [31:0]         rd_nxt;

  // one answer per request: waitrequest drops for exactly one cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      bus_state_r <= rfog_pkg::BUS_IDLE;
      wait_r      <= 1'b1;
    end
    else
    begin
      case (bus_state_r)
        rfog_pkg::BUS_IDLE:
        begin
          if (AVS_READ || AVS_WRITE)
          begin
            bus_state_r <= rfog_pkg::BUS_ANSWER;
            wait_r      <= 1'b0;
          end
        end
        rfog_pkg::BUS_ANSWER:
        begin
          bus_state_r <= rfog_pkg::BUS_IDLE;
          wait_r      <= 1'b1;
        end
        default:
        begin
          bus_state_r <= rfog_pkg::BUS_IDLE;
          wait_r      <= 1'b1;
        end
      endcase
    end
  end

  // write commits at the edge where the master sees waitrequest low;
  // both low byte lanes are needed, a half word would split a field
  assign word_wr = AVS_WRITE && !wait_r
                   && (idx_of(AVS_ADDRESS) == rfog_pkg::IDX_CTRL_PORT)
                   && (AVS_BYTEENABLE[1:0] == 2'h3);
  assign word    = AVS_WRITEDATA[rfog_pkg::WORD_W-1:0];

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      last_word_r <= rfog_pkg::RST_WORD;
    else if (word_wr)
      last_word_r <= word;
  end

  // selects live in the mode register; only these two bits are kept
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      sumsel_r <= 1'b0;
      phsrc_r  <= 1'b0;
    end
    else if (word_wr && sel_is(word, rfog_pkg::SEL_MODES))
    begin
      sumsel_r <= word[rfog_pkg::SUMSEL_BIT];
      phsrc_r  <= word[rfog_pkg::PHSRC_BIT];
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      altmode_r  <= 1'b0;
      foff_off_r <= 1'b0;
      frac_r     <= rfog_pkg::RST_FRAC;
    end
    else if (word_wr && sel_is(word, rfog_pkg::SEL_FOCUS))
    begin
      altmode_r  <= word[rfog_pkg::ALTMODE_BIT];
      foff_off_r <= word[rfog_pkg::FOFF_OFF_BIT];
      frac_r     <= word[rfog_pkg::FRAC_HI:rfog_pkg::FRAC_LO];
    end
  end

  // code 11 on the first stage is refused: that stage keeps its gain
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      g1_r <= rfog_pkg::RST_G1;
      g2_r <= rfog_pkg::RST_G2;
      g3_r <= rfog_pkg::RST_G3;
    end
    else if (word_wr && sel_is(word, rfog_pkg::SEL_GAIN))
    begin
      if (word[rfog_pkg::G1_HI:rfog_pkg::G1_LO] != rfog_pkg::G1_UNUSED)
        g1_r <= word[rfog_pkg::G1_HI:rfog_pkg::G1_LO];
      g2_r <= word[rfog_pkg::G2_HI:rfog_pkg::G2_LO];
      g3_r <= word[rfog_pkg::G3_HI:rfog_pkg::G3_LO];
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      left_r  <= rfog_pkg::RST_OFFS;
      right_r <= rfog_pkg::RST_OFFS;
    end
    else if (word_wr && sel_is(word, rfog_pkg::SEL_LR_OFFS))
    begin
      left_r  <= word[rfog_pkg::LEFT_HI:rfog_pkg::LEFT_LO];
      right_r <= word[rfog_pkg::RIGHT_HI:rfog_pkg::RIGHT_LO];
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      sumf_r <= rfog_pkg::RST_OFFS;
    else if (word_wr && sel_is(word, rfog_pkg::SEL_SUM_OFFS))
      sumf_r <= word[rfog_pkg::SUMF_HI:rfog_pkg::SUMF_LO];
  end

  // the low field is stored in every mode but steered only where it applies
  rfog_route u_route
  (
    .clk                        (SYS_CLK),
    .rst                        (RESET),
    .summed_input_select        (sumsel_r),
    .phase_offset_source_select (phsrc_r),
    .lr_left_field              (left_r),
    .lr_right_field             (right_r),
    .sum_field                  (sumf_r),
    .left_code                  (conv_left),
    .right_code                 (conv_right),
    .summed_code                (conv_sum),
    .phase_code                 (conv_phase)
  );

  // read-back of stored contents with the select nibble restored
  always_comb
  begin
    rd_nxt = '0;
    case (idx_of(AVS_ADDRESS))
      rfog_pkg::IDX_MODES:
      begin
        rd_nxt[rfog_pkg::SEL_HI:rfog_pkg::SEL_LO] = rfog_pkg::SEL_MODES;
        rd_nxt[rfog_pkg::SUMSEL_BIT]              = sumsel_r;
        rd_nxt[rfog_pkg::PHSRC_BIT]               = phsrc_r;
      end
      rfog_pkg::IDX_FOCUS:
      begin
        rd_nxt[rfog_pkg::SEL_HI:rfog_pkg::SEL_LO]     = rfog_pkg::SEL_FOCUS;
        rd_nxt[rfog_pkg::ALTMODE_BIT]                 = altmode_r;
        rd_nxt[rfog_pkg::FOFF_OFF_BIT]                = foff_off_r;
        rd_nxt[rfog_pkg::FRAC_HI:rfog_pkg::FRAC_LO]   = frac_r;
      end
      rfog_pkg::IDX_GAIN:
      begin
        rd_nxt[rfog_pkg::SEL_HI:rfog_pkg::SEL_LO] = rfog_pkg::SEL_GAIN;
        rd_nxt[rfog_pkg::G1_HI:rfog_pkg::G1_LO]   = g1_r;
        rd_nxt[rfog_pkg::G2_HI:rfog_pkg::G2_LO]   = g2_r;
        rd_nxt[rfog_pkg::G3_HI:rfog_pkg::G3_LO]   = g3_r;
      end
      rfog_pkg::IDX_LR_OFFS:
      begin
        rd_nxt[rfog_pkg::SEL_HI:rfog_pkg::SEL_LO]     = rfog_pkg::SEL_LR_OFFS;
        rd_nxt[rfog_pkg::LEFT_HI:rfog_pkg::LEFT_LO]   = left_r;
        rd_nxt[rfog_pkg::RIGHT_HI:rfog_pkg::RIGHT_LO] = right_r;
      end
      rfog_pkg::IDX_SUM_OFFS:
      begin
        rd_nxt[rfog_pkg::SEL_HI:rfog_pkg::SEL_LO]   = rfog_pkg::SEL_SUM_OFFS;
        rd_nxt[rfog_pkg::SUMF_HI:rfog_pkg::SUMF_LO] = sumf_r;
      end
      rfog_pkg::IDX_CTRL_PORT:
        rd_nxt[rfog_pkg::WORD_W-1:0] = last_word_r;
      rfog_pkg::IDX_CONV_STAT:
      begin
        rd_nxt[rfog_pkg::STAT_PH_LO  +: rfog_pkg::OFFS_W] = conv_phase;
        rd_nxt[rfog_pkg::STAT_SUM_LO +: rfog_pkg::OFFS_W] = conv_sum;
        rd_nxt[rfog_pkg::STAT_L_LO   +: rfog_pkg::OFFS_W] = conv_left;
        rd_nxt[rfog_pkg::STAT_R_LO   +: rfog_pkg::OFFS_W] = conv_right;
      end
      default:
        rd_nxt = '0;
    endcase
  end

  // read data captured as waitrequest drops, so it stands at that edge
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
      rdata_r <= '0;
    else if (AVS_READ && bus_state_r == rfog_pkg::BUS_IDLE)
      rdata_r <= rd_nxt;
  end

  // outputs, one flop stage after the stored fields; converter codes two
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      ALTERNATE_OPERATING_MODE   <= 1'b0;
      FOCUS_FULL_RANGE_OFFSET_ON <= 1'b1;
      FOCUS_OFFSET_FRACTION      <= rfog_pkg::RST_FRAC;
    end
    else
    begin
      ALTERNATE_OPERATING_MODE   <= altmode_r;
      FOCUS_FULL_RANGE_OFFSET_ON <= ~foff_off_r;
      FOCUS_OFFSET_FRACTION      <= frac_r;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      FIRST_STAGE_GAIN_CODE     <= rfog_pkg::RST_G1;
      SECOND_STAGE_GAIN_CODE    <= rfog_pkg::RST_G2;
      THIRD_STAGE_GAIN_CODE     <= rfog_pkg::RST_G3;
      FIRST_STAGE_GAIN_DB       <= g1_db(rfog_pkg::RST_G1);
      SECOND_STAGE_GAIN_DB      <= g2_db(rfog_pkg::RST_G2);
      THIRD_STAGE_GAIN_TENTH_DB <= g3_tdb(rfog_pkg::RST_G3);
    end
    else
    begin
      FIRST_STAGE_GAIN_CODE     <= g1_r;
      SECOND_STAGE_GAIN_CODE    <= g2_r;
      THIRD_STAGE_GAIN_CODE     <= g3_r;
      FIRST_STAGE_GAIN_DB       <= g1_db(g1_r);
      SECOND_STAGE_GAIN_DB      <= g2_db(g2_r);
      THIRD_STAGE_GAIN_TENTH_DB <= g3_tdb(g3_r);
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      SUMMED_INPUT_SELECT        <= 1'b0;
      PHASE_OFFSET_SOURCE_SELECT <= 1'b0;
      LEFT_CHANNEL_OFFSET_CODE   <= rfog_pkg::RST_OFFS;
      RIGHT_CHANNEL_OFFSET_CODE  <= rfog_pkg::RST_OFFS;
      SUMMED_CHANNEL_OFFSET_CODE <= rfog_pkg::RST_OFFS;
      PHASE_DETECTOR_OFFSET_CODE <= rfog_pkg::RST_OFFS;
    end
    else
    begin
      SUMMED_INPUT_SELECT        <= sumsel_r;
      PHASE_OFFSET_SOURCE_SELECT <= phsrc_r;
      LEFT_CHANNEL_OFFSET_CODE   <= conv_left;
      RIGHT_CHANNEL_OFFSET_CODE  <= conv_right;
      SUMMED_CHANNEL_OFFSET_CODE <= conv_sum;
      PHASE_DETECTOR_OFFSET_CODE <= conv_phase;
    end
  end

  assign AVS_READDATA    = rdata_r;
  assign AVS_WAITREQUEST = wait_r;

endmodule : rfog_regs
`default_nettype wire

// >>> logic/rfog_pkg.sv
// rfog_pkg: register indices, field layouts, select codes and reset values
// of the focus offset / rf gain / rf offset register bank.
// assumes 16-bit control words whose top nibble selects the register.
package rfog_pkg;

  // control word layout
  localparam int          WORD_W        = 16;
  localparam int          SEL_HI        = 15;
  localparam int          SEL_LO        = 12;
  localparam int          SEL_W         = 4;

  // register select codes carried in the top nibble
  localparam logic [3:0]  SEL_MODES     = 4'h1;
  localparam logic [3:0]  SEL_FOCUS     = 4'h2;
  localparam logic [3:0]  SEL_GAIN      = 4'h3;
  localparam logic [3:0]  SEL_LR_OFFS   = 4'h4;
  localparam logic [3:0]  SEL_SUM_OFFS  = 4'h5;

  // register indices; the byte address is four times the index
  localparam logic [3:0]  IDX_MODES     = 4'h1;
  localparam logic [3:0]  IDX_FOCUS     = 4'h2;
  localparam logic [3:0]  IDX_GAIN      = 4'h3;
  localparam logic [3:0]  IDX_LR_OFFS   = 4'h4;
  localparam logic [3:0]  IDX_SUM_OFFS  = 4'h5;
  localparam logic [3:0]  IDX_CTRL_PORT = 4'h8;
  localparam logic [3:0]  IDX_CONV_STAT = 4'h9;

  // avalon byte address, data and byte enable widths
  localparam int          ADDR_W        = 6;
  localparam int          DATA_W        = 32;
  localparam int          BE_W          = 4;

  // mode register fields
  localparam int          SUMSEL_BIT    = 0;
  localparam int          PHSRC_BIT     = 11;

  // focus offset register fields
  localparam int          ALTMODE_BIT   = 11;
  localparam int          FOFF_OFF_BIT  = 10;
  localparam int          FRAC_HI       = 9;
  localparam int          FRAC_LO       = 5;
  localparam int          FRAC_W        = 5;

  // rf gain register fields
  localparam int          G1_HI         = 11;
  localparam int          G1_LO         = 10;
  localparam int          G2_HI         = 9;
  localparam int          G2_LO         = 8;
  localparam int          G3_HI         = 7;
  localparam int          G3_LO         = 4;
  localparam logic [1:0]  G1_UNUSED     = 2'h3;

  // offset register fields
  localparam int          LEFT_HI       = 11;
  localparam int          LEFT_LO       = 6;
  localparam int          RIGHT_HI      = 5;
  localparam int          RIGHT_LO      = 0;
  localparam int          SUMF_HI       = 5;
  localparam int          SUMF_LO       = 0;
  localparam int          OFFS_W        = 6;

  // converter status packing
  localparam int          STAT_PH_LO    = 0;
  localparam int          STAT_SUM_LO   = 8;
  localparam int          STAT_L_LO     = 16;
  localparam int          STAT_R_LO     = 24;

  // gain figures in dB and tenths of dB
  localparam logic [4:0]  G1_STEP_DB    = 5'h06;
  localparam logic [4:0]  G2_BASE_DB    = 5'h06;
  localparam logic [4:0]  G2_STEP_DB    = 5'h06;
  localparam logic [7:0]  G3_STEP_TDB   = 8'h08;

  // reset values
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [1:0]  RST_G2        = 2'h0;
  localparam logic [1:0]  RST_G1        = 2'h0;
  localparam logic [3:0]  RST_G3        = 4'h0;
  localparam logic [4:0]  RST_FRAC      = 5'h00;
  localparam logic [5:0]  RST_OFFS      = 6'h00;

  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ANSWER
  } rfog_bus_t;

endpackage : rfog_pkg

// >>> logic/rfog_route.sv
// rfog_route: steers the stored rf offset fields onto the four offset
// converters according to summed input select and phase source select.
// assumes all inputs are registered in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module rfog_route
(
  // clock and reset
  input  wire  logic       clk,
  input  wire  logic       rst,
  // source selects
  input  wire  logic       summed_input_select,
  input  wire  logic       phase_offset_source_select,
  // stored fields
  input  wire  logic [5:0] lr_left_field,
  input  wire  logic [5:0] lr_right_field,
  input  wire  logic [5:0] sum_field,
  // converter codes
  output logic       [5:0] left_code,
  output logic       [5:0] right_code,
  output logic       [5:0] summed_code,
  output logic       [5:0] phase_code
);

  // converters not addressed in the current mode keep their last code
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      left_code  <= rfog_pkg::RST_OFFS;
      right_code <= rfog_pkg::RST_OFFS;
    end
    else if (!summed_input_select)
    begin
      left_code  <= lr_left_field;
      right_code <= lr_right_field;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      summed_code <= rfog_pkg::RST_OFFS;
    else if (summed_input_select && !phase_offset_source_select)
      summed_code <= lr_right_field;
    else if (summed_input_select && phase_offset_source_select)
      summed_code <= sum_field;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      phase_code <= rfog_pkg::RST_OFFS;
    else if (phase_offset_source_select)
      phase_code <= sum_field;
    else if (summed_input_select)
      phase_code <= lr_right_field;
    else
      phase_code <= lr_left_field;
  end

endmodule : rfog_route
`default_nettype wire

// >>> verif/rfog_regs_assertions.sv
// rfog_regs_chk: handshake, field loading and converter routing of rfog_regs.
// assumes it is bound into rfog_regs; one clock domain, sync reset.
`timescale 1ns/1ps
`default_nettype none
module rfog_regs_chk
(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  // avalon-mm slave
  input  wire logic [5:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  input  wire logic        AVS_WAITREQUEST,
  // watched controls
  input  wire logic        ALTERNATE_OPERATING_MODE,
  input  wire logic        FOCUS_FULL_RANGE_OFFSET_ON,
  input  wire logic [4:0]  FOCUS_OFFSET_FRACTION,
  input  wire logic [1:0]  FIRST_STAGE_GAIN_CODE,
  input  wire logic        SUMMED_INPUT_SELECT,
  input  wire logic        PHASE_OFFSET_SOURCE_SELECT,
  input  wire logic [5:0]  LEFT_CHANNEL_OFFSET_CODE,
  input  wire logic [5:0]  SUMMED_CHANNEL_OFFSET_CODE,
  input  wire logic [5:0]  PHASE_DETECTOR_OFFSET_CODE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  logic       req;
  logic       wacc;
  logic [3:0] sel;
  assign req  = AVS_READ | AVS_WRITE;
  assign sel  = AVS_WRITEDATA[15:12];
  // only a full low half-word at the control port counts as a word
  assign wacc = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[1:0] == 2'h3
                && AVS_ADDRESS[5:2] == rfog_pkg::IDX_CTRL_PORT;

  a_wait_answer: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("no answer one cycle after request");
  a_wait_idle: assert property (!req |=> AVS_WAITREQUEST)
    else $error("answer without request");
  a_focus_alt: assert property (wacc && sel == 4'h2
    |-> ##3 ALTERNATE_OPERATING_MODE == $past(AVS_WRITEDATA[11], 3))
    else $error("alternate mode not loaded");
  a_focus_inverted: assert property (wacc && sel == 4'h2
    |-> ##3 FOCUS_FULL_RANGE_OFFSET_ON == !$past(AVS_WRITEDATA[10], 3))
    else $error("focus offset enable polarity wrong");
  a_focus_fraction: assert property (wacc && sel == 4'h2
    |-> ##3 FOCUS_OFFSET_FRACTION == $past(AVS_WRITEDATA[9:5], 3))
    else $error("focus fraction not loaded");
  a_gain_first: assert property (wacc && sel == 4'h3 && AVS_WRITEDATA[11:10] != 2'h3
    |-> ##3 FIRST_STAGE_GAIN_CODE == $past(AVS_WRITEDATA[11:10], 3))
    else $error("first stage gain not loaded");
  a_gain_unused: assert property (wacc && sel == 4'h3 && AVS_WRITEDATA[11:10] == 2'h3
    |-> ##3 FIRST_STAGE_GAIN_CODE == $past(FIRST_STAGE_GAIN_CODE, 2))
    else $error("unused first stage code took effect");
  a_left_route: assert property (wacc && sel == 4'h4 && !SUMMED_INPUT_SELECT
    |-> ##4 SUMMED_INPUT_SELECT
        || LEFT_CHANNEL_OFFSET_CODE == $past(AVS_WRITEDATA[11:6], 4))
    else $error("left converter not following left field");
  a_summed_shared: assert property (wacc && sel == 4'h4 && SUMMED_INPUT_SELECT
    && !PHASE_OFFSET_SOURCE_SELECT |-> ##4 !SUMMED_INPUT_SELECT || PHASE_OFFSET_SOURCE_SELECT
    || (SUMMED_CHANNEL_OFFSET_CODE == $past(AVS_WRITEDATA[5:0], 4)
        && PHASE_DETECTOR_OFFSET_CODE == $past(AVS_WRITEDATA[5:0], 4)))
    else $error("shared summed and phase code wrong");
  a_sum_route: assert property (wacc && sel == 4'h5 && SUMMED_INPUT_SELECT
    && PHASE_OFFSET_SOURCE_SELECT |-> ##4 !SUMMED_INPUT_SELECT || !PHASE_OFFSET_SOURCE_SELECT
    || SUMMED_CHANNEL_OFFSET_CODE == $past(AVS_WRITEDATA[5:0], 4))
    else $error("summed converter not following sum field");
endmodule : rfog_regs_chk
`default_nettype wire

// >>> verif/rfog_host.sv
// rfog_host: avalon-mm master standing in for the host controller.
// assumes a slave that answers with waitrequest low within 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module rfog_host
(
  // clock
  input  wire logic        SYS_CLK,
  // avalon-mm master
  input  wire logic        AVS_WAITREQUEST,
  output logic       [5:0]  AVS_ADDRESS,
  output logic              AVS_READ,
  output logic              AVS_WRITE,
  output logic       [31:0] AVS_WRITEDATA,
  output logic       [3:0]  AVS_BYTEENABLE,
  // bus hang flag
  output logic              HANG
);
  initial
  begin
    {AVS_ADDRESS, AVS_READ, AVS_WRITE, AVS_WRITEDATA, AVS_BYTEENABLE, HANG} = '0;
  end

  // request held whole until the edge that sees waitrequest low
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    AVS_ADDRESS    <= a;
    AVS_WRITEDATA  <= d;
    AVS_BYTEENABLE <= be;
    AVS_WRITE      <= wr;
    AVS_READ       <= !wr;
    @(posedge SYS_CLK);
    while (AVS_WAITREQUEST !== 1'b0 && n < 20)
    begin
      @(posedge SYS_CLK);
      n++;
    end
    if (n >= 20)
      HANG = 1'b1;
    AVS_WRITE <= 1'b0;
    AVS_READ  <= 1'b0;
  endtask : xfer
endmodule : rfog_host
`default_nettype wire

// >>> verif/rfog_regs_test.sv
// rfog_regs_test: self-checking bench for the focus, gain and offset bank.
// assumes rfog_host as bus master and rfog_regs_chk bound to the design.
`timescale 1ns/1ps
`default_nettype none
module rfog_regs_test;
  logic        SYS_CLK = 1'b0;
  logic        RESET = 1'b1;
  wire         AVS_READ, AVS_WRITE, AVS_WAITREQUEST, HANG;
  wire  [31:0] AVS_WRITEDATA, AVS_READDATA;
  wire  [5:0]  AVS_ADDRESS;
  wire  [3:0]  AVS_BYTEENABLE, THIRD_STAGE_GAIN_CODE;
  wire         ALTERNATE_OPERATING_MODE, FOCUS_FULL_RANGE_OFFSET_ON;
  wire         SUMMED_INPUT_SELECT, PHASE_OFFSET_SOURCE_SELECT;
  wire  [4:0]  FOCUS_OFFSET_FRACTION, FIRST_STAGE_GAIN_DB, SECOND_STAGE_GAIN_DB;
  wire  [1:0]  FIRST_STAGE_GAIN_CODE, SECOND_STAGE_GAIN_CODE;
  wire  [7:0]  THIRD_STAGE_GAIN_TENTH_DB;
  wire  [5:0]  LEFT_CHANNEL_OFFSET_CODE, RIGHT_CHANNEL_OFFSET_CODE;
  wire  [5:0]  SUMMED_CHANNEL_OFFSET_CODE, PHASE_DETECTOR_OFFSET_CODE;
  logic [31:0] exp_q[$];
  int          n_mismatch = 0;
  int          check_count = 0;
  int          seed = 39;
  int          i;
  logic [31:0] w;
  logic [15:0] fw;
  logic [5:0]  ml, mr, ms, el, er, es, ep;
  logic [1:0]  g1, g2;
  logic [3:0]  g3;

  rfog_regs u_rfog_regs (.*);
  rfog_host u_rfog_host (.*);

  initial
  begin
    forever #20 SYS_CLK = ~SYS_CLK;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // for a read, d is the expected read data
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    if (!wr)
      exp_q.push_back(d);
    u_rfog_host.xfer(wr, a, wr ? d : 32'h0, be);
    if (HANG)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask : bus

  // converter codes reach the ports two cycles after the commit
  task automatic settle;
    repeat (5) @(posedge SYS_CLK);
  endtask : settle

  always @(posedge SYS_CLK)
  begin
    if (AVS_READ && AVS_WAITREQUEST === 1'b0)
    begin
      if (exp_q.size() == 0)
        check("read_queue", 32'h1, 32'h0);
      else
        check("readdata", AVS_READDATA, exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (2) @(posedge SYS_CLK);
    RESET <= 1'b0;
    @(posedge SYS_CLK);
    check("foff_on", 32'(FOCUS_FULL_RANGE_OFFSET_ON), 32'h1);
    check("g2_db", 32'(SECOND_STAGE_GAIN_DB), 32'h6);
    for (i = 0; i < 4; i++)
    begin
      w = $random(seed);
      fw = {4'h2, w[11:0]};
      bus(1'b1, 6'h20, {16'h0, fw}, 4'h3);
      settle();
      check("alt_mode", 32'(ALTERNATE_OPERATING_MODE), 32'(fw[11]));
      check("foff_on", 32'(FOCUS_FULL_RANGE_OFFSET_ON), 32'(!fw[10]));
      check("fraction", 32'(FOCUS_OFFSET_FRACTION), 32'(fw[9:5]));
    end
    for (i = 0; i < 12; i++)
    begin
      w = $random(seed);
      g1 = 2'(i % 3);
      g2 = 2'(i % 4);
      g3 = w[7:4];
      bus(1'b1, 6'h20, {16'h0, 4'h3, g1, g2, g3, w[3:0]}, 4'hF);
      if (i == 11)
      begin
        g2 = ~g2;
        g3 = ~g3;
        bus(1'b1, 6'h20, {16'h0, 4'h3, 2'h3, g2, g3, 4'h0}, 4'hF);
      end
      settle();
      check("g1", 32'(FIRST_STAGE_GAIN_CODE), 32'(g1));
      check("g1_db", 32'(FIRST_STAGE_GAIN_DB), 32'(g1) * 6);
      check("g2", 32'(SECOND_STAGE_GAIN_CODE), 32'(g2));
      check("g2_db", 32'(SECOND_STAGE_GAIN_DB), 32'(g2) * 6 + 6);
      check("g3", 32'(THIRD_STAGE_GAIN_CODE), 32'(g3));
      check("g3_tdb", 32'(THIRD_STAGE_GAIN_TENTH_DB), 32'(g3) * 8);
    end
    {ml, mr, ms, el, er, es, ep} = '0;
    for (i = 0; i < 8; i++)
    begin
      bus(1'b1, 6'h20, {16'h0, 4'h1, i[1], 10'h0, i[0]}, 4'hF);
      w = $random(seed);
      {ml, mr} = w[11:0];
      bus(1'b1, 6'h20, {16'h0, 4'h4, w[11:0]}, 4'hF);
      w = $random(seed);
      ms = w[5:0];
      bus(1'b1, 6'h20, {16'h0, 4'h5, w[11:0]}, 4'hF);
      // converters that the mode does not address keep their code
      if (!i[0])
      begin
        el = ml;
        er = mr;
        ep = i[1] ? ms : ml;
      end
      else
      begin
        es = i[1] ? ms : mr;
        ep = es;
      end
      settle();
      check("left", 32'(LEFT_CHANNEL_OFFSET_CODE), 32'(el));
      check("right", 32'(RIGHT_CHANNEL_OFFSET_CODE), 32'(er));
      check("summed", 32'(SUMMED_CHANNEL_OFFSET_CODE), 32'(es));
      check("phase", 32'(PHASE_DETECTOR_OFFSET_CODE), 32'(ep));
      check("sum_sel", 32'(SUMMED_INPUT_SELECT), 32'(i[0]));
      check("ph_src", 32'(PHASE_OFFSET_SOURCE_SELECT), 32'(i[1]));
      bus(1'b0, 6'h04, {16'h0, 4'h1, i[1], 10'h0, i[0]}, 4'hF);
      bus(1'b0, 6'h10, {16'h0, 4'h4, ml, mr}, 4'hF);
      bus(1'b0, 6'h14, {16'h0, 4'h5, 6'h0, ms}, 4'hF);
      bus(1'b0, 6'h24, {2'h0, er, 2'h0, el, 2'h0, es, 2'h0, ep}, 4'hF);
    end
    bus(1'b1, 6'h20, {16'h0, 4'h6, 12'hFFF}, 4'hF);
    bus(1'b1, 6'h20, {16'h0, 4'h2, ~fw[11:0]}, 4'hC);
    bus(1'b1, 6'h08, {16'h0, 4'h2, ~fw[11:0]}, 4'hF);
    bus(1'b0, 6'h3C, 32'h0, 4'hF);
    bus(1'b0, 6'h08, {16'h0, fw[15:5], 5'h0}, 4'hF);
    bus(1'b0, 6'h0C, {16'h0, 4'h3, g1, g2, g3, 4'h0}, 4'hF);
    bus(1'b0, 6'h20, {16'h0, 16'h6FFF}, 4'hF);
    settle();
    check("fraction", 32'(FOCUS_OFFSET_FRACTION), 32'(fw[9:5]));
    check("alt_mode", 32'(ALTERNATE_OPERATING_MODE), 32'(fw[11]));
    finish_test();
  end
endmodule : rfog_regs_test

bind rfog_regs rfog_regs_chk u_rfog_regs_chk (.*);
`default_nettype wire
